//--- design/rsq_pkg.sv
package rsq_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_MODEM_CFG = 8'h00;
    localparam logic [7:0] ADDR_PKT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_GAIN_CTRL = 8'h08;
    localparam logic [7:0] ADDR_PIN_CFG = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_PKT_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_STATUS_BYTE = 8'h20;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h24;
    // field positions
    localparam int SYNC_MODE_LSB = 0;
    localparam int PQT_LSB = 0;
    localparam int APPEND_BIT = 3;
    localparam int ABS_OFS_LSB = 0;
    localparam int REL_THR_LSB = 4;
    localparam int MAG_TGT_LSB = 8;
    localparam int FILT_LEN_LSB = 12;
    localparam int PIN0_LSB = 0;
    localparam int PIN1_LSB = 8;
    localparam int ST_PQ_BIT = 0;
    localparam int ST_CS_BIT = 1;
    localparam int ST_SYNC_BIT = 2;
    localparam int ST_PIN0_BIT = 3;
    localparam int ST_PIN1_BIT = 4;
    localparam int IRQ_SYNC = 0;
    localparam int IRQ_PQ = 1;
    localparam int IRQ_CS = 2;
    // reset values
    localparam logic [2:0] SYNC_MODE_RST = 3'h2;
    localparam logic [3:0] ABS_OFS_RST = 4'h0;
    localparam logic [2:0] MAG_TGT_RST = 3'h3;
    localparam logic [1:0] REL_THR_RST = 2'h0;
    localparam logic [1:0] FILT_LEN_RST = 2'h1;
    localparam logic [5:0] PIN_RST = 6'h00;
    // pin select codes
    localparam logic [5:0] PIN_SEL_PQ = 6'h08;
    localparam logic [5:0] PIN_SEL_CS = 6'h0E;
    localparam logic [5:0] PIN_SEL_SYNC = 6'h06;
    // counter arithmetic
    localparam logic [7:0] PQ_DEC = 8'h08;
    localparam int HYST_HALF_DB = 2;
    localparam logic [31:0] BUS_OKAY = 32'h0;
endpackage : rsq_pkg

//--- design/rsq_qualifiers.sv
`timescale 1ns/1ps
// What this block does
// - no fifo writes before qualifying sync in modes 1..3 and 5..7
// - sync mode selects bit-match requirement
// - modes 4..7 add carrier sense requirement
// - preamble counter: +1 toggle, -8 repeat
// - sync gated until counter reaches 4*threshold
// - preamble reached flag in status, pin code 8
// - level tracks until sync, frozen until rx
// - level is two's complement half-dB
// - level updates at filter-length derived rate
// - append places last level in status byte
// - absolute sense with hysteresis around threshold
// - relative sense on dB step between samples
// - sync search only while sense asserted in modes 5..7
// - sense in status and pin code 14
// - absolute offset spans -7..+7 dB steps
// - reset: offset 0, magnitude target 3
module rsq_qualifiers
    import rsq_pkg::*;
#(
    parameter int LEVEL_W = 8,
    parameter int BASE_DIV = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hsel_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic rx_state_enter_i,
    input wire logic rx_active_i,
    input wire logic bit_valid_i,
    input wire logic bit_i,
    input wire logic [LEVEL_W-1:0] level_sample_i,
    input wire logic level_valid_i,
    input wire logic [5:0] sync_errors_16_i,
    input wire logic [5:0] sync_errors_32_i,
    input wire logic sync_window_i,
    input wire logic payload_end_i,
    output logic sync_found_o,
    output logic fifo_write_en_o,
    output logic [7:0] status_byte_o,
    output logic status_byte_valid_o,
    output logic carrier_sense_o,
    output logic pin0_o,
    output logic pin1_o,
    output logic irq_o
);
    // elaboration checks; the 11-bit rate counter must hold BASE_DIV*8
    if (LEVEL_W != 8) begin : g_bad_level_w
        $error("level width must be 8");
    end
    if (BASE_DIV < 1 || BASE_DIV > 256) begin : g_bad_div
        $error("base divider must be 1 to 256");
    end

    // host register state
    logic [2:0] sync_mode_q, sync_mode_d;
    logic [2:0] pqt_q, pqt_d;
    logic append_q, append_d;
    logic [3:0] abs_ofs_q, abs_ofs_d;
    logic [1:0] rel_thr_q, rel_thr_d;
    logic [2:0] mag_tgt_q, mag_tgt_d;
    logic [1:0] filt_len_q, filt_len_d;
    logic [5:0] pin0_sel_q, pin0_sel_d, pin1_sel_q, pin1_sel_d;
    logic [2:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d;
    logic signed [7:0] thr_base_q, thr_base_d;
    // bus pipeline
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    // qualifier state
    logic [7:0] pq_cnt_q, pq_cnt_d;
    logic prev_bit_q, prev_bit_d, have_bit_q, have_bit_d;
    logic [7:0] level_q, level_d, last_level_q, last_level_d;
    logic frozen_q, frozen_d;
    logic [10:0] rate_cnt_q, rate_cnt_d;
    logic cs_abs_q, cs_abs_d, cs_rel_q, cs_rel_d;
    logic synced_q, synced_d;
    logic sync_pulse_q, sync_pulse_d;
    logic [7:0] sbyte_q, sbyte_d;
    logic sbyte_v_q, sbyte_v_d;
    logic pin0_q, pin0_d, pin1_q, pin1_d, irq_q, irq_d;
    logic pq_prev_q, pq_prev_d, cs_prev_q, cs_prev_d;

    // pin multiplexer used for both output pins
    function automatic logic pin_mux(input logic [5:0] sel, input logic pq,
                                     input logic cs, input logic sy);
        case (sel)
            PIN_SEL_PQ: pin_mux = pq;
            PIN_SEL_CS: pin_mux = cs;
            PIN_SEL_SYNC: pin_mux = sy;
            default: pin_mux = 1'b0;
        endcase
    endfunction : pin_mux

    // relative step in half-dB units: code 0 disables, else 6/10/14 dB
    function automatic logic signed [9:0] rel_step(input logic [1:0] code);
        rel_step = 10'(signed'({6'h00, code}) * 8 + 4);
    endfunction : rel_step

    // shared qualifier terms
    logic pq_reached, cs_now, bits_ok, sync_hit;
    logic signed [9:0] thr_eff, lvl_s, diff;

    // combinational qualifier terms
    always_comb begin
        pq_reached = (pqt_q == 3'h0) || (pq_cnt_q >= {3'h0, pqt_q, 2'h0});
        cs_now = cs_abs_q || cs_rel_q;
        case (sync_mode_q[1:0])
            2'h0: bits_ok = 1'b1;
            2'h1: bits_ok = sync_errors_16_i <= 6'h01;
            2'h2: bits_ok = sync_errors_16_i == 6'h00;
            default: bits_ok = sync_errors_32_i <= 6'h02;
        endcase
        // modes 0 and 4 need no sync; the others need the gates
        sync_hit = sync_window_i && bits_ok && pq_reached
                   && (!sync_mode_q[2] || cs_now);
        // offset field is a signed 4-bit dB count, doubled into half-dB
        thr_eff = 10'(thr_base_q)
                + (10'(signed'(abs_ofs_q)) <<< 1);
        lvl_s = 10'(signed'(level_q));
        diff = 10'(signed'(level_sample_i)) - lvl_s;
    end

    // next-state logic for everything
    always_comb begin
        sync_mode_d = sync_mode_q;
        pqt_d = pqt_q;
        append_d = append_q;
        abs_ofs_d = abs_ofs_q;
        rel_thr_d = rel_thr_q;
        mag_tgt_d = mag_tgt_q;
        filt_len_d = filt_len_q;
        pin0_sel_d = pin0_sel_q;
        pin1_sel_d = pin1_sel_q;
        irq_mask_d = irq_mask_q;
        thr_base_d = thr_base_q;
        irq_st_d = irq_st_q;
        hrdata_d = hrdata_q;
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        pq_cnt_d = pq_cnt_q;
        prev_bit_d = prev_bit_q;
        have_bit_d = have_bit_q;
        level_d = level_q;
        last_level_d = last_level_q;
        frozen_d = frozen_q;
        rate_cnt_d = rate_cnt_q;
        cs_abs_d = cs_abs_q;
        cs_rel_d = cs_rel_q;
        synced_d = synced_q;
        sync_pulse_d = 1'b0;
        sbyte_d = sbyte_q;
        sbyte_v_d = 1'b0;
        // address phase: reads answer in the next cycle, writes land then
        if (hsel_i && hready_i && htrans_i[1]) begin
            if (hwrite_i) begin
                wr_pend_d = 1'b1;
                wr_addr_d = haddr_i[7:0];
            end else begin
                case (haddr_i[7:0])
                    ADDR_MODEM_CFG: hrdata_d = {29'h0, sync_mode_q};
                    ADDR_PKT_CTRL: hrdata_d = {28'h0, append_q, pqt_q};
                    ADDR_GAIN_CTRL: hrdata_d = {18'h0, filt_len_q, 1'b0, mag_tgt_q,
                                                2'h0, rel_thr_q, abs_ofs_q};
                    ADDR_PIN_CFG: hrdata_d = {18'h0, pin1_sel_q, 2'h0, pin0_sel_q};
                    ADDR_LEVEL: hrdata_d = {24'h0, level_q};
                    ADDR_PKT_STATUS: hrdata_d = {27'h0, pin1_q, pin0_q, synced_q,
                                                 carrier_sense_o, pq_reached};
                    ADDR_IRQ_STATUS: hrdata_d = {29'h0, irq_st_q};
                    ADDR_IRQ_MASK: hrdata_d = {29'h0, irq_mask_q};
                    ADDR_STATUS_BYTE: hrdata_d = {24'h0, sbyte_q};
                    ADDR_RX_CTRL: hrdata_d = {24'h0, thr_base_q};
                    default: hrdata_d = 32'h0;
                endcase
            end
        end
        // data phase: the write lands at its end
        if (wr_pend_q) begin
            case (wr_addr_q)
                ADDR_MODEM_CFG: sync_mode_d = hwdata_i[SYNC_MODE_LSB +: 3];
                ADDR_PKT_CTRL: begin
                    pqt_d = hwdata_i[PQT_LSB +: 3];
                    append_d = hwdata_i[APPEND_BIT];
                end
                ADDR_GAIN_CTRL: begin
                    // offset code 8 (-8 dB) is out of range, clamp to -7
                    abs_ofs_d = (hwdata_i[ABS_OFS_LSB +: 4] == 4'h8) ? 4'h9
                              : hwdata_i[ABS_OFS_LSB +: 4];
                    rel_thr_d = hwdata_i[REL_THR_LSB +: 2];
                    mag_tgt_d = hwdata_i[MAG_TGT_LSB +: 3];
                    filt_len_d = hwdata_i[FILT_LEN_LSB +: 2];
                end
                ADDR_PIN_CFG: begin
                    pin0_sel_d = hwdata_i[PIN0_LSB +: 6];
                    pin1_sel_d = hwdata_i[PIN1_LSB +: 6];
                end
                ADDR_IRQ_MASK: irq_mask_d = hwdata_i[2:0];
                ADDR_IRQ_STATUS: irq_st_d = irq_st_q & ~hwdata_i[2:0];
                ADDR_RX_CTRL: thr_base_d = hwdata_i[7:0];
                default: ;
            endcase
        end
        // preamble quality estimator, saturating at both ends
        if (bit_valid_i) begin
            prev_bit_d = bit_i;
            have_bit_d = 1'b1;
            if (have_bit_q && bit_i != prev_bit_q) begin
                if (pq_cnt_q != 8'hFF) pq_cnt_d = pq_cnt_q + 8'h01;
            end else if (have_bit_q) begin
                pq_cnt_d = (pq_cnt_q > PQ_DEC) ? pq_cnt_q - PQ_DEC : 8'h00;
            end
        end
        // level sampling divided down by BASE_DIV times 2^filter length
        if (level_valid_i) begin
            if (rate_cnt_q == 11'(BASE_DIV * (1 << filt_len_q)) - 11'h1) begin
                rate_cnt_d = 11'h0;
                if (!frozen_q) level_d = level_sample_i;
                last_level_d = level_sample_i;
                // relative sense on step from the stored level (frozen after sync) to the new sample
                if (rel_thr_q != 2'h0) begin
                    if (diff >= rel_step(rel_thr_q)) cs_rel_d = 1'b1;
                    else if (diff <= -rel_step(rel_thr_q)) cs_rel_d = 1'b0;
                end else begin
                    cs_rel_d = 1'b0;
                end
            end else begin
                rate_cnt_d = rate_cnt_q + 11'h1;
            end
        end
        // absolute sense with a small hysteresis band
        if (lvl_s > thr_eff + 10'(HYST_HALF_DB)) cs_abs_d = 1'b1;
        else if (lvl_s < thr_eff - 10'(HYST_HALF_DB)) cs_abs_d = 1'b0;
        // sync detection, then freeze until the next rx entry
        if (rx_active_i && !synced_q && sync_mode_q[1:0] != 2'h0 && sync_hit) begin
            synced_d = 1'b1;
            frozen_d = 1'b1;
            sync_pulse_d = 1'b1;
        end
        // status byte takes the newest sample, frozen or not
        if (payload_end_i && append_q) begin
            sbyte_d = last_level_q;
            sbyte_v_d = 1'b1;
        end
        // entering rx restarts the sync and preamble qualifiers, not carrier sense
        if (rx_state_enter_i) begin
            frozen_d = 1'b0;
            synced_d = 1'b0;
            pq_cnt_d = 8'h00;
            have_bit_d = 1'b0;
        end
        // events set after the clear so a same-cycle set wins
        if (sync_pulse_d) irq_st_d[IRQ_SYNC] = 1'b1;
        if (pq_reached && !pq_prev_q) irq_st_d[IRQ_PQ] = 1'b1;
        if (cs_now && !cs_prev_q) irq_st_d[IRQ_CS] = 1'b1;
    end

    // registered outputs
    always_comb begin
        pq_prev_d = pq_reached;
        cs_prev_d = cs_now;
        pin0_d = pin_mux(pin0_sel_q, pq_reached, cs_now, synced_q);
        pin1_d = pin_mux(pin1_sel_q, pq_reached, cs_now, synced_q);
        irq_d = |(irq_st_d & irq_mask_d);
    end

    // output flops for sense and the fifo gate
    logic cs_out_q, fifo_en_q;
    // registers; thresholds reset to offset 0, magnitude 3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_mode_q <= SYNC_MODE_RST;
            pqt_q <= 3'h0;
            append_q <= 1'b0;
            abs_ofs_q <= ABS_OFS_RST;
            mag_tgt_q <= MAG_TGT_RST;
            rel_thr_q <= REL_THR_RST;
            filt_len_q <= FILT_LEN_RST;
            pin0_sel_q <= PIN_RST;
            pin1_sel_q <= PIN_RST;
            irq_st_q <= 3'h0;
            irq_mask_q <= 3'h0;
            thr_base_q <= 8'h0;
            hrdata_q <= 32'h0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            pq_cnt_q <= 8'h00;
            prev_bit_q <= 1'b0;
            have_bit_q <= 1'b0;
            level_q <= 8'h80;
            last_level_q <= 8'h80;
            frozen_q <= 1'b0;
            rate_cnt_q <= 11'h0;
            cs_abs_q <= 1'b0;
            cs_rel_q <= 1'b0;
            synced_q <= 1'b0;
            sync_pulse_q <= 1'b0;
            sbyte_q <= 8'h00;
            sbyte_v_q <= 1'b0;
            pin0_q <= 1'b0;
            pin1_q <= 1'b0;
            irq_q <= 1'b0;
            pq_prev_q <= 1'b0;
            cs_prev_q <= 1'b0;
            cs_out_q <= 1'b0;
            fifo_en_q <= 1'b0;
        end else begin
            sync_mode_q <= sync_mode_d;
            pqt_q <= pqt_d;
            append_q <= append_d;
            abs_ofs_q <= abs_ofs_d;
            mag_tgt_q <= mag_tgt_d;
            rel_thr_q <= rel_thr_d;
            filt_len_q <= filt_len_d;
            pin0_sel_q <= pin0_sel_d;
            pin1_sel_q <= pin1_sel_d;
            irq_st_q <= irq_st_d;
            irq_mask_q <= irq_mask_d;
            thr_base_q <= thr_base_d;
            hrdata_q <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            pq_cnt_q <= pq_cnt_d;
            prev_bit_q <= prev_bit_d;
            have_bit_q <= have_bit_d;
            level_q <= level_d;
            last_level_q <= last_level_d;
            frozen_q <= frozen_d;
            rate_cnt_q <= rate_cnt_d;
            cs_abs_q <= cs_abs_d;
            cs_rel_q <= cs_rel_d;
            synced_q <= synced_d;
            sync_pulse_q <= sync_pulse_d;
            sbyte_q <= sbyte_d;
            sbyte_v_q <= sbyte_v_d;
            pin0_q <= pin0_d;
            pin1_q <= pin1_d;
            irq_q <= irq_d;
            pq_prev_q <= pq_prev_d;
            cs_prev_q <= cs_prev_d;
            cs_out_q <= cs_abs_d || cs_rel_d;
            // mode 0/4: no sync needed, mode 4 still waits on sense
            fifo_en_q <= rx_active_i && (sync_mode_d[1:0] == 2'h0
                         ? (!sync_mode_d[2] || cs_abs_d || cs_rel_d) : synced_d);
        end
    end

    // single-cycle answers, never wait states, always okay
    assign hrdata_o = hrdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = BUS_OKAY[0];
    assign sync_found_o = sync_pulse_q;
    assign fifo_write_en_o = fifo_en_q;
    assign status_byte_o = sbyte_q;
    assign status_byte_valid_o = sbyte_v_q;
    assign carrier_sense_o = cs_out_q;
    assign pin0_o = pin0_q;
    assign pin1_o = pin1_q;
    assign irq_o = irq_q;
endmodule : rsq_qualifiers

//--- test/rsq_qualifiers_props.sv
`timescale 1ns/1ps
// watches bus answers and qualifier outputs of the top level
module rsq_qualifiers_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic rx_active_i,
    input wire logic sync_window_i,
    input wire logic [5:0] sync_errors_16_i,
    input wire logic [5:0] sync_errors_32_i,
    input wire logic payload_end_i,
    input wire logic sync_found_o,
    input wire logic fifo_write_en_o,
    input wire logic status_byte_valid_o,
    input wire logic carrier_sense_o,
    input wire logic irq_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a found pulse needs a compare window in receive one cycle earlier
    sync_cause_a: assert property (sync_found_o |->
        $past(sync_window_i) && $past(rx_active_i)) else $error("sync without window");
    // the loosest match still allows only one of 16 or two of 32 wrong
    sync_match_a: assert property (sync_found_o |->
        $past(sync_errors_16_i) <= 6'h01 || $past(sync_errors_32_i) <= 6'h02)
        else $error("sync on poor match");
    sync_pulse_a: assert property (sync_found_o |=> !sync_found_o)
        else $error("sync pulse too long");
    fifo_open_a: assert property (sync_found_o |-> ##[0:1] fifo_write_en_o)
        else $error("fifo closed after sync");
    sbyte_cause_a: assert property (status_byte_valid_o |-> $past(payload_end_i))
        else $error("status byte without payload end");
    sbyte_pulse_a: assert property (status_byte_valid_o |=> !status_byte_valid_o)
        else $error("status byte pulse too long");
    // read data moves only after a read address phase, so reads have no side paths
    rdata_hold_a: assert property ($changed(hrdata_o) |->
        $past(hsel_i) && $past(htrans_i[1]) && !$past(hwrite_i)) else $error("read data moved");
    bus_okay_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or error");
    rst_low_a: assert property ($fell(rst_i) |-> !sync_found_o && !fifo_write_en_o &&
        !carrier_sense_o && !irq_o) else $error("output high out of reset");
    sync_seen_c: cover property (sync_found_o);
    sbyte_seen_c: cover property (status_byte_valid_o);
    sense_rise_c: cover property ($rose(carrier_sense_o));
    irq_seen_c: cover property (irq_o);
endmodule : rsq_qualifiers_props

bind rsq_qualifiers rsq_qualifiers_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .rx_active_i(rx_active_i), .sync_window_i(sync_window_i),
    .sync_errors_16_i(sync_errors_16_i), .sync_errors_32_i(sync_errors_32_i),
    .payload_end_i(payload_end_i), .sync_found_o(sync_found_o),
    .fifo_write_en_o(fifo_write_en_o), .status_byte_valid_o(status_byte_valid_o),
    .carrier_sense_o(carrier_sense_o), .irq_o(irq_o)
);

//--- test/rsq_demod_model.sv
`timescale 1ns/1ps
// demodulator stand-in: idle lines show the inverse of the last value, never a kind copy
module rsq_demod_model (
    input wire logic clk_i,
    output logic rx_enter_o,
    output logic rx_active_o,
    output logic bit_valid_o,
    output logic bit_o,
    output logic [7:0] level_o,
    output logic level_valid_o,
    output logic [5:0] err16_o,
    output logic [5:0] err32_o,
    output logic window_o,
    output logic payload_end_o
);
    logic lastb;
    initial begin
        {rx_enter_o, rx_active_o, bit_valid_o, bit_o, level_valid_o, window_o} = '0;
        {payload_end_o, level_o, err16_o, err32_o, lastb} = '0;
    end
    // entry pulse, then stay in receive
    task automatic enter_rx();
        @(posedge clk_i);
        rx_enter_o <= 1'b1;
        rx_active_o <= 1'b1;
        @(posedge clk_i);
        rx_enter_o <= 1'b0;
    endtask : enter_rx
    // alt toggles every bit, otherwise the last bit repeats
    task automatic send_bits(input int n, input logic alt);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            lastb = alt ? ~lastb : lastb;
            bit_valid_o <= 1'b1;
            bit_o <= lastb;
        end
        @(posedge clk_i);
        bit_valid_o <= 1'b0;
        bit_o <= ~lastb;
    endtask : send_bits
    task automatic send_level(input logic [7:0] v, input int n);
        repeat (n) begin
            @(posedge clk_i);
            level_valid_o <= 1'b1;
            level_o <= v;
            @(posedge clk_i);
            level_valid_o <= 1'b0;
            level_o <= ~v;
        end
    endtask : send_level
    // compare result is valid for its one window cycle only
    task automatic sync_try(input logic [5:0] e16, input logic [5:0] e32);
        @(posedge clk_i);
        window_o <= 1'b1;
        err16_o <= e16;
        err32_o <= e32;
        @(posedge clk_i);
        window_o <= 1'b0;
        err16_o <= ~e16;
        err32_o <= ~e32;
    endtask : sync_try
    task automatic end_payload();
        @(posedge clk_i);
        payload_end_o <= 1'b1;
        @(posedge clk_i);
        payload_end_o <= 1'b0;
    endtask : end_payload
endmodule : rsq_demod_model

//--- test/test_rsq_qualifiers.sv
`timescale 1ns/1ps
module test_rsq_qualifiers;
    import rsq_pkg::*;
    logic clk_i, rst_i, hsel, hwrite, rd_pend, ok, sbv;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata_o;
    logic hreadyout_o, hresp_o, sync_found_o, fifo_write_en_o, carrier_sense_o;
    logic pin0_o, pin1_o, irq_o, rx_enter, rx_active, bit_valid, bit_v, level_valid;
    logic window, payload_end;
    logic [7:0] sbyte, level;
    logic [5:0] err16, err32;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    logic [7:0] sb_q[$];
    logic [16:0] tbl[11];
    int num_errors = 0;
    int n_checks = 0;
    int seed = 4;
    int n_sync = 0;
    rsq_qualifiers u_rsq_qualifiers (
        .clk_i(clk_i), .rst_i(rst_i), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hsel_i(hsel), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .rx_state_enter_i(rx_enter), .rx_active_i(rx_active), .bit_valid_i(bit_valid),
        .bit_i(bit_v), .level_sample_i(level), .level_valid_i(level_valid),
        .sync_errors_16_i(err16), .sync_errors_32_i(err32), .sync_window_i(window),
        .payload_end_i(payload_end), .sync_found_o(sync_found_o),
        .fifo_write_en_o(fifo_write_en_o), .status_byte_o(sbyte), .status_byte_valid_o(sbv),
        .carrier_sense_o(carrier_sense_o), .pin0_o(pin0_o), .pin1_o(pin1_o), .irq_o(irq_o)
    );
    rsq_demod_model u_dm (
        .clk_i(clk_i), .rx_enter_o(rx_enter), .rx_active_o(rx_active), .bit_valid_o(bit_valid),
        .bit_o(bit_v), .level_o(level), .level_valid_o(level_valid), .err16_o(err16),
        .err32_o(err32), .window_o(window), .payload_end_o(payload_end)
    );
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // a hung bus ends the run rather than the simulation limit
    task automatic wait_rdy();
        int k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (hreadyout_o !== 1'b1 && k < 50);
        if (hreadyout_o !== 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_rdy
    // settle past the edge so registered outputs have landed
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wt
    // single word transfer; a read leaves its expected value and mask in the queue
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        if (!wr) exp_q.push_back({m, d});
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus
    // read words and status bytes are compared with the oldest note
    always @(posedge clk_i) begin
        if (rd_pend) begin
            note = exp_q.pop_front();
            check(hrdata_o & note[63:32], note[31:0]);
        end
        if (sbv) check({24'h0, sbyte}, {24'h0, sb_q.pop_front()});
        if (!rst_i && sync_found_o !== 1'b0) n_sync++;
        rd_pend <= hsel && htrans[1] && !hwrite && !rst_i;
    end
    initial begin
        {rst_i, hsel, hwrite, rd_pend} = 4'h8;
        htrans = 2'h0;
        {haddr, hwdata} = '0;
        tbl = '{17'h00000, 17'h10004, 17'h10000, 17'h000FC, 17'h00306, 17'h1030A,
                17'h10306, 17'h00302, 17'h11010, 17'h11012, 17'h01004};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values; random writes to read-only and unmapped words change nothing
        bus(0, ADDR_MODEM_CFG, 32'h2, 32'h7);
        bus(0, ADDR_GAIN_CTRL, 32'h1300, 32'h373F);
        bus(1, ADDR_LEVEL, $random(seed), 0);
        bus(1, 8'h40, $random(seed), 0);
        bus(0, ADDR_LEVEL, 32'h80, 32'hFF);
        bus(0, 8'h40, 32'h0, 32'hFFFFFFFF);
        // threshold 4: first bit seeds, toggles add one, a repeat takes eight
        bus(1, ADDR_PIN_CFG, 32'h0E08, 0);
        bus(1, ADDR_GAIN_CTRL, 32'h0300, 0);
        bus(1, ADDR_RX_CTRL, 32'h0, 0);
        bus(1, ADDR_PKT_CTRL, 32'h1, 0);
        bus(1, ADDR_MODEM_CFG, 32'h1, 0);
        u_dm.enter_rx();
        u_dm.send_bits(4, 1'b1);
        wt(3);
        check(pin0_o, 0);
        u_dm.sync_try(6'h0, 6'h0);
        wt(3);
        check(fifo_write_en_o, 0);
        u_dm.send_bits(1, 1'b1);
        wt(3);
        check(pin0_o, 1);
        bus(0, ADDR_PKT_STATUS, 32'h9, 32'h9);
        u_dm.send_bits(1, 1'b0);
        wt(3);
        check(pin0_o, 0);
        u_dm.send_bits(4, 1'b1);
        u_dm.sync_try(6'h0, 6'h0);
        wt(3);
        check(fifo_write_en_o, 1);
        // all modes with one of 16 and two of 32 bits wrong, sense low then high
        bus(1, ADDR_PKT_CTRL, 32'h0, 0);
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 8; m++) begin
                bus(1, ADDR_MODEM_CFG, m, 0);
                u_dm.enter_rx();
                u_dm.send_level(s ? 8'h20 : 8'hE0, 4);
                u_dm.sync_try(6'h1, 6'h2);
                wt(3);
                ok = (m % 4 == 1 || m % 4 == 3) && (m < 4 || s == 1);
                check(pin1_o, s);
                check(fifo_write_en_o, m % 4 == 0 ? (m < 4 || s == 1) : ok);
                bus(0, ADDR_PKT_STATUS, {ok, s[0], 1'b0}, 32'h6);
            end
        end
        // newest sample, here equal to the level frozen at sync, goes to the status byte; next rx entry thaws it
        bus(1, ADDR_PKT_CTRL, 32'h8, 0);
        sb_q.push_back(8'h20);
        u_dm.end_payload();
        u_dm.send_level(8'h40, 4);
        bus(0, ADDR_LEVEL, 32'h20, 32'hFF);
        bus(0, ADDR_STATUS_BYTE, 32'h20, 32'hFF);
        u_dm.enter_rx();
        u_dm.send_level(8'hC4, 4);
        bus(0, ADDR_LEVEL, 32'hC4, 32'hFF);
        // latched sync event: masked, unmasked, then cleared by a written one
        bus(1, ADDR_IRQ_MASK, 32'h0, 0);
        wt(2);
        check(irq_o, 0);
        bus(1, ADDR_IRQ_MASK, 32'h1, 0);
        wt(2);
        check(irq_o, 1);
        bus(1, ADDR_IRQ_STATUS, 32'h1, 0);
        wt(2);
        check(irq_o, 0);
        bus(0, ADDR_IRQ_STATUS, 32'h0, 32'h1);
        // absolute sense with offset and hysteresis, then relative steps over a high floor
        for (int i = 0; i < 11; i++) begin
            if (i == 8) bus(1, ADDR_RX_CTRL, 32'h7F, 0);
            bus(1, ADDR_GAIN_CTRL, {24'h3, tbl[i][15:8]}, 0);
            u_dm.send_level(tbl[i][7:0], 4);
            wt(3);
            check(carrier_sense_o, tbl[i][16]);
        end
        check(n_sync, 7);
        complete_run();
    end
endmodule : test_rsq_qualifiers
